// [oag_core.sv]
// Notes on behaviour
// - register addresses valid 0-127 and 240-255
// - working register: pointer high nibble above field
// - register pair: even, 0-126 or 240-254
// - working pair: even designator 0 to 14
// - indirect: register content is operand address
// - program/data memory indirect needs a pair
// - indexed: base plus working register, load only
// - direct address only for jump and call
// - relative: signed byte displacement, two branches only
// - relative base is next instruction address
// - immediate: operand field is the value
// - nibble 1110 escapes to working register
// - short and long designators mix freely
//
// Purpose: operand effective-address generation between decoder and register file
// Assumes: register file read data is valid one cycle after rf_rd_en
// Notes:   one request at a time; req_ready low while a request is in flight
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`default_nettype none

module oag_core (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               ce,
  input  wire logic               req_valid,
  input  wire oag_pkg::oag_mode_e  req_mode,
  input  wire oag_pkg::oag_kind_e  req_kind,
  input  wire oag_pkg::oag_space_e req_space,
  input  wire logic               req_short,
  input  wire logic [7:0]         req_desig,
  input  wire logic [7:0]         req_base,
  input  wire logic [3:0]         req_index,
  input  wire logic [7:0]         req_field,
  input  wire logic [15:0]        req_direct,
  input  wire logic [7:0]         reg_ptr,
  input  wire logic [15:0]        pc_next,
  input  wire logic [7:0]         rf_rd_data,
  output logic                    req_ready,
  output logic                    rf_rd_en,
  output logic [7:0]              rf_rd_addr,
  output logic                    ea_valid,
  output logic [15:0]             ea_addr,
  output oag_pkg::oag_space_e      ea_space,
  output logic                    ea_pair,
  output logic                    ea_imm,
  output logic [7:0]              ea_imm_data,
  output logic                    ea_err,
  output oag_pkg::oag_err_e        ea_err_code
);
  import oag_pkg::*;

  typedef enum logic [2:0] {
    OAG_ST_IDLE,
    OAG_ST_RDH,
    OAG_ST_CAPH,
    OAG_ST_RDL,
    OAG_ST_CAPL
  } oag_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // designator resolution

  logic [7:0] des_addr;
  logic       des_work;
  logic       des_ok;
  logic       des_even;
  logic [7:0] idx_addr;

  oag_resolve u_des (
    .desig      (req_desig),
    .short_form (req_short),
    .reg_ptr    (reg_ptr),
    .addr       (des_addr),
    .working    (des_work),
    .in_range   (des_ok),
    .even       (des_even)
  );

  // the index is always a working register, so it rides the short form
  oag_resolve u_idx (
    .desig      ({OAG_ESC_NIBBLE, req_index}),
    .short_form (1'b1),
    .reg_ptr    (reg_ptr),
    .addr       (idx_addr),
    .working    (),
    .in_range   (),
    .even       ()
  );

  logic pair_ok;
  always_comb begin
    if (des_work) begin
      pair_ok = des_even && (des_addr[3:0] <= OAG_WPAIR_MAX);
    end else begin
      pair_ok = des_even && ((des_addr <= OAG_PAIR_LOW_MAX) ||
                ((des_addr >= OAG_HIGH_MIN) && (des_addr <= OAG_PAIR_HI_MAX)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state

  oag_state_e state_q, state_d;
  oag_mode_e  mode_q, mode_d;
  oag_space_e space_q, space_d;
  logic [7:0] base_q, base_d;
  logic [7:0] hi_q, hi_d;
  logic [7:0] rd_addr_q, rd_addr_d;
  logic       valid_q, valid_d;
  logic [15:0] addr_q, addr_d;
  oag_space_e osp_q, osp_d;
  logic       pair_q, pair_d;
  logic       imm_q, imm_d;
  logic [7:0] imm_data_q, imm_data_d;
  oag_err_e   err_q, err_d;

  logic [15:0] disp_ext;
  assign disp_ext = {{8{req_field[7]}}, req_field};

  always_comb begin
    state_d    = state_q;
    mode_d     = mode_q;
    space_d    = space_q;
    base_d     = base_q;
    hi_d       = hi_q;
    rd_addr_d  = rd_addr_q;
    valid_d    = 1'b0;
    addr_d     = addr_q;
    osp_d      = osp_q;
    pair_d     = pair_q;
    imm_d      = imm_q;
    imm_data_d = imm_data_q;
    err_d      = err_q;
    case (state_q)
      OAG_ST_IDLE: begin
        if (req_valid) begin
          mode_d     = req_mode;
          space_d    = req_space;
          base_d     = req_base;
          addr_d     = {OAG_RST_BYTE, des_addr};
          osp_d      = OAG_S_REG;
          pair_d     = 1'b0;
          imm_d      = 1'b0;
          imm_data_d = OAG_RST_BYTE;
          err_d      = OAG_E_NONE;
          rd_addr_d  = des_addr;
          case (req_mode)
            OAG_M_REG: begin
              valid_d = 1'b1;
              if (!des_ok) begin
                err_d = OAG_E_RANGE;
              end
            end
            OAG_M_PAIR: begin
              valid_d = 1'b1;
              pair_d  = 1'b1;
              if (!pair_ok) begin
                err_d = des_even ? OAG_E_RANGE : OAG_E_ODD;
              end
            end
            OAG_M_IND: begin
              // a single register cannot hold a 16-bit memory address
              if (req_space != OAG_S_REG) begin
                valid_d = 1'b1;
                err_d   = OAG_E_SPACE;
              end else if (!des_ok) begin
                valid_d = 1'b1;
                err_d   = OAG_E_RANGE;
              end else begin
                state_d = OAG_ST_RDH;
              end
            end
            OAG_M_IND_PAIR: begin
              if ((req_space != OAG_S_PROG) && (req_space != OAG_S_DATA)) begin
                valid_d = 1'b1;
                err_d   = OAG_E_SPACE;
              end else if (!pair_ok) begin
                valid_d = 1'b1;
                err_d   = des_even ? OAG_E_RANGE : OAG_E_ODD;
              end else begin
                state_d = OAG_ST_RDH;
              end
            end
            OAG_M_IDX: begin
              rd_addr_d = idx_addr;
              if (req_kind != OAG_K_LOAD) begin
                valid_d = 1'b1;
                err_d   = OAG_E_MODE;
              end else begin
                state_d = OAG_ST_RDH;
              end
            end
            OAG_M_DIR: begin
              valid_d = 1'b1;
              osp_d   = OAG_S_PROG;
              addr_d  = req_direct;
              if ((req_kind != OAG_K_COND_JUMP) && (req_kind != OAG_K_CALL)) begin
                err_d = OAG_E_MODE;
              end
            end
            OAG_M_REL: begin
              valid_d = 1'b1;
              osp_d   = OAG_S_PROG;
              addr_d  = pc_next + disp_ext;
              if ((req_kind != OAG_K_REL_JUMP) && (req_kind != OAG_K_DEC_BRANCH)) begin
                err_d = OAG_E_MODE;
              end
            end
            OAG_M_IMM: begin
              valid_d    = 1'b1;
              osp_d      = OAG_S_NONE;
              imm_d      = 1'b1;
              imm_data_d = req_field;
              addr_d     = OAG_RST_WORD;
            end
            default: begin
              valid_d = 1'b1;
              err_d   = OAG_E_MODE;
            end
          endcase
          // branch classes own the relative mode and nothing else
          if (((req_kind == OAG_K_REL_JUMP) || (req_kind == OAG_K_DEC_BRANCH)) &&
              (req_mode != OAG_M_REL)) begin
            valid_d = 1'b1;
            state_d = OAG_ST_IDLE;
            err_d   = OAG_E_MODE;
          end
        end
      end
      OAG_ST_RDH: begin
        state_d = OAG_ST_CAPH;
      end
      OAG_ST_CAPH: begin
        if (mode_q == OAG_M_IND_PAIR) begin
          hi_d      = rf_rd_data;
          rd_addr_d = rd_addr_q + 8'h01;
          state_d   = OAG_ST_RDL;
        end else if (mode_q == OAG_M_IDX) begin
          valid_d = 1'b1;
          state_d = OAG_ST_IDLE;
          addr_d  = {OAG_RST_BYTE, base_q + rf_rd_data};
          if (!oag_rf_ok(base_q + rf_rd_data)) begin
            err_d = OAG_E_RANGE;
          end
        end else begin
          valid_d = 1'b1;
          state_d = OAG_ST_IDLE;
          addr_d  = {OAG_RST_BYTE, rf_rd_data};
          if (!oag_rf_ok(rf_rd_data)) begin
            err_d = OAG_E_RANGE;
          end
        end
      end
      OAG_ST_RDL: begin
        state_d = OAG_ST_CAPL;
      end
      OAG_ST_CAPL: begin
        valid_d = 1'b1;
        state_d = OAG_ST_IDLE;
        osp_d   = space_q;
        addr_d  = {hi_q, rf_rd_data};
      end
      default: begin
        state_d = OAG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q    <= OAG_ST_IDLE;
      mode_q     <= OAG_M_REG;
      space_q    <= OAG_S_REG;
      base_q     <= OAG_RST_BYTE;
      hi_q       <= OAG_RST_BYTE;
      rd_addr_q  <= OAG_RST_BYTE;
      valid_q    <= 1'b0;
      addr_q     <= OAG_RST_WORD;
      osp_q      <= OAG_S_REG;
      pair_q     <= 1'b0;
      imm_q      <= 1'b0;
      imm_data_q <= OAG_RST_BYTE;
      err_q      <= OAG_E_NONE;
    end else if (ce) begin
      state_q    <= state_d;
      mode_q     <= mode_d;
      space_q    <= space_d;
      base_q     <= base_d;
      hi_q       <= hi_d;
      rd_addr_q  <= rd_addr_d;
      valid_q    <= valid_d;
      addr_q     <= addr_d;
      osp_q      <= osp_d;
      pair_q     <= pair_d;
      imm_q      <= imm_d;
      imm_data_q <= imm_data_d;
      err_q      <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // handshakes are combinational; a frozen ce stretches them with the state
  assign req_ready   = (state_q == OAG_ST_IDLE);
  assign rf_rd_en    = (state_q == OAG_ST_RDH) || (state_q == OAG_ST_RDL);
  assign rf_rd_addr  = rd_addr_q;
  assign ea_valid    = valid_q;
  assign ea_addr     = addr_q;
  assign ea_space    = osp_q;
  assign ea_pair     = pair_q;
  assign ea_imm      = imm_q;
  assign ea_imm_data = imm_data_q;
  assign ea_err      = (err_q != OAG_E_NONE);
  assign ea_err_code = err_q;

endmodule // oag_core

`default_nettype wire

// [oag_monitor.sv]
// Purpose: port checker for oag_core
// Assumes: ce high whenever a result is judged
// Notes:   bound to every oag_core instance
`timescale 1ns/100ps
`default_nettype none
module oag_monitor
  import oag_pkg::*;
(
  input wire logic               clk,
  input wire logic               srst,
  input wire logic               ce,
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire oag_pkg::oag_mode_e  req_mode,
  input wire oag_pkg::oag_kind_e  req_kind,
  input wire oag_pkg::oag_space_e req_space,
  input wire logic               req_short,
  input wire logic [7:0]         req_desig,
  input wire logic [7:0]         req_field,
  input wire logic [15:0]        req_direct,
  input wire logic [7:0]         reg_ptr,
  input wire logic [15:0]        pc_next,
  input wire logic               rf_rd_en,
  input wire logic               ea_valid,
  input wire logic               ea_err,
  input wire logic [15:0]        ea_addr,
  input wire oag_pkg::oag_space_e ea_space,
  input wire logic               ea_imm,
  input wire logic [7:0]         ea_imm_data,
  input wire oag_pkg::oag_err_e   ea_err_code
);
  logic        tk;
  logic        oth;
  logic [15:0] rel_q;
  logic [7:0]  wrk_q;
  assign tk  = ce && req_valid && req_ready;
  assign oth = req_kind == OAG_K_OTHER;
  // expected addresses kept one edge, compared at the result
  always_ff @(posedge clk) begin
    rel_q <= pc_next + {{8{req_field[7]}}, req_field};
    wrk_q <= {reg_ptr[7:4], req_desig[3:0]};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
////////////////////////////////////////////////////////////
  a_reg_answer: assert property (tk && req_mode == OAG_M_REG |=> ea_valid)
    else $error("register result late");
  a_range_err: assert property (tk && req_mode == OAG_M_REG && !req_short && oth &&
    req_desig inside {[8'h80:8'hDF]} |=> ea_err_code == OAG_E_RANGE)
    else $error("bad register accepted");
  a_work_addr: assert property (tk && req_mode == OAG_M_REG && oth &&
    (req_short || req_desig[7:4] == OAG_ESC_NIBBLE) |=> ea_addr == {8'h00, wrk_q})
    else $error("working address wrong");
  a_pair_odd: assert property (tk && req_mode == OAG_M_PAIR && req_desig[0] && oth
    |=> ea_err && ea_err_code == OAG_E_ODD)
    else $error("odd pair accepted");
  a_ind_read: assert property (tk && req_mode == OAG_M_IND && req_space == OAG_S_REG
    && oth && !req_desig[7] |=> rf_rd_en ##2 ea_valid)
    else $error("indirect read order");
  a_ind_space: assert property (tk && req_mode == OAG_M_IND && req_space != OAG_S_REG
    && oth |=> ea_err_code == OAG_E_SPACE)
    else $error("memory indirect via single register");
  a_idx_load: assert property (tk && req_mode == OAG_M_IDX && req_kind != OAG_K_LOAD
    |=> ea_err_code == OAG_E_MODE)
    else $error("indexed outside load");
  a_dir_dest: assert property (tk && req_mode == OAG_M_DIR &&
    req_kind inside {OAG_K_COND_JUMP, OAG_K_CALL}
    |=> ea_addr == $past(req_direct) && ea_space == OAG_S_PROG)
    else $error("direct destination wrong");
  a_rel_sum: assert property (tk && req_mode == OAG_M_REL &&
    req_kind inside {OAG_K_REL_JUMP, OAG_K_DEC_BRANCH} |=> ea_addr == rel_q)
    else $error("relative destination wrong");
  a_imm_value: assert property (tk && req_mode == OAG_M_IMM && oth
    |=> ea_imm && ea_imm_data == $past(req_field))
    else $error("immediate value wrong");
  a_pair_busy: assert property (tk && req_mode == OAG_M_IND_PAIR &&
    req_kind == OAG_K_LOAD && req_space == OAG_S_PROG && !req_short && !req_desig[7] &&
    !req_desig[0] |=> !req_ready [*4] ##1 (ea_valid && req_ready))
    else $error("pair indirect busy window wrong");
  c_ind_pair: cover property (tk && req_mode == OAG_M_IND_PAIR);
  c_rel: cover property (tk && req_mode == OAG_M_REL);
  c_err: cover property (ea_valid && ea_err);
endmodule // oag_monitor
bind oag_core oag_monitor u_mon (.clk, .srst, .ce, .req_valid, .req_ready, .req_mode,
  .req_kind, .req_space, .req_short, .req_desig, .req_field, .req_direct, .reg_ptr,
  .pc_next, .rf_rd_en, .ea_valid, .ea_err, .ea_addr, .ea_space, .ea_imm, .ea_imm_data,
  .ea_err_code);
`default_nettype wire

// [oag_resolve.sv]
// Purpose: package of the operand address generator and its designator resolver
// Assumes: register pointer keeps the working-set base in its upper nibble
// Notes:   resolver is purely combinational; the main module registers its results
////////////////////////////////////////////////////////////////////////////////
`default_nettype none

package oag_pkg;

  // addressing modes presented by the decoder
  typedef enum logic [3:0] {
    OAG_M_REG,
    OAG_M_PAIR,
    OAG_M_IND,
    OAG_M_IND_PAIR,
    OAG_M_IDX,
    OAG_M_DIR,
    OAG_M_REL,
    OAG_M_IMM
  } oag_mode_e;

  // instruction class, as far as address generation cares
  typedef enum logic [2:0] {
    OAG_K_OTHER,
    OAG_K_LOAD,
    OAG_K_COND_JUMP,
    OAG_K_CALL,
    OAG_K_REL_JUMP,
    OAG_K_DEC_BRANCH
  } oag_kind_e;

  // space that the effective address points into
  typedef enum logic [1:0] {
    OAG_S_REG,
    OAG_S_PROG,
    OAG_S_DATA,
    OAG_S_NONE
  } oag_space_e;

  typedef enum logic [2:0] {
    OAG_E_NONE,
    OAG_E_RANGE,
    OAG_E_ODD,
    OAG_E_MODE,
    OAG_E_SPACE
  } oag_err_e;

  localparam logic [3:0]  OAG_ESC_NIBBLE   = 4'hE;
  localparam logic [7:0]  OAG_LOW_MAX      = 8'h7F;
  localparam logic [7:0]  OAG_HIGH_MIN     = 8'hF0;
  localparam logic [7:0]  OAG_PAIR_LOW_MAX = 8'h7E;
  localparam logic [7:0]  OAG_PAIR_HI_MAX  = 8'hFE;
  localparam logic [3:0]  OAG_WPAIR_MAX    = 4'hE;
  localparam logic [7:0]  OAG_RST_BYTE     = 8'h00;
  localparam logic [15:0] OAG_RST_WORD     = 16'h0000;

  // 0-127 and 240-255 are the populated register-file addresses
  function automatic logic oag_rf_ok(input logic [7:0] a);
    oag_rf_ok = (a <= OAG_LOW_MAX) || (a >= OAG_HIGH_MIN);
  endfunction

endpackage

////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps

module oag_resolve (
  input  wire logic [7:0] desig,
  input  wire logic       short_form,
  input  wire logic [7:0] reg_ptr,
  output logic      [7:0] addr,
  output logic            working,
  output logic            in_range,
  output logic            even
);
  import oag_pkg::*;

  always_comb begin
    working = short_form || (desig[7:4] == OAG_ESC_NIBBLE);
    if (working) begin
      addr = {reg_ptr[7:4], desig[3:0]};
    end else begin
      addr = desig;
    end
    in_range = oag_rf_ok(addr);
    even     = ~addr[0];
  end

endmodule // oag_resolve

`default_nettype wire

// [tb.sv]
// Purpose: directed bench for oag_core
// Assumes: ce high except one freeze check; register file answers address xor 5a
// Notes:   request held until the next one replaces it
`timescale 1ns/100ps
`default_nettype none
module tb;
  import oag_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, ce = 1'b1, req_valid = 1'b0, req_short = 1'b0;
  logic        pend = 1'b0;
  oag_mode_e   req_mode = OAG_M_REG;
  oag_kind_e   req_kind = OAG_K_OTHER;
  oag_space_e  req_space = OAG_S_REG;
  logic [7:0]  req_desig = 8'h00, req_base = 8'h00, req_field = 8'h00;
  logic [7:0]  reg_ptr = 8'h00, rf_rd_data = 8'h00, pa;
  logic [3:0]  req_index = 4'h0;
  logic [15:0] req_direct = 16'h0000, pc_next = 16'h0000;
  logic        req_ready, rf_rd_en, ea_valid, ea_pair, ea_imm, ea_err;
  logic [7:0]  rf_rd_addr, ea_imm_data;
  logic [15:0] ea_addr;
  oag_space_e  ea_space;
  oag_err_e    ea_err_code;
  int          error_cnt = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  oag_core dut (.clk, .srst, .ce, .req_valid, .req_mode, .req_kind, .req_space, .req_short,
    .req_desig, .req_base, .req_index, .req_field, .req_direct, .reg_ptr, .pc_next,
    .rf_rd_data, .req_ready, .rf_rd_en, .rf_rd_addr, .ea_valid, .ea_addr, .ea_space,
    .ea_pair, .ea_imm, .ea_imm_data, .ea_err, .ea_err_code);
  // read data only in the cycle after a read; otherwise it toggles
  always @(posedge clk) begin
    pend <= rf_rd_en;
    pa   <= rf_rd_addr;
  end
  always @(negedge clk) rf_rd_data <= pend ? pa ^ 8'h5A : ~rf_rd_data;
////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    tests_run++;
    if (s !== x) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic er(input oag_err_e e);
    chk("ea_err_code", ea_err_code, e);
  endtask
  task automatic ck(input logic [15:0] a, input oag_err_e e);
    chk("ea_addr", ea_addr, a);
    er(e);
  endtask
  task automatic go(input oag_mode_e m, input logic [7:0] d,
                    input oag_kind_e k = OAG_K_OTHER, input oag_space_e s = OAG_S_REG);
    int n;
    n = 0;
    req_mode = m;
    req_kind = k;
    req_space = s;
    req_desig = d;
    req_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    while (ea_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      $display("[ERR] ea_valid expected 1 seen timeout");
    end
  endtask
  task t_reg;
    go(OAG_M_REG, 8'h7F); ck(16'h007F, OAG_E_NONE);
    go(OAG_M_REG, 8'hF0); ck(16'h00F0, OAG_E_NONE);
    go(OAG_M_REG, 8'h80); er(OAG_E_RANGE);
  endtask
  task t_work;
    reg_ptr = 8'h50;
    req_short = 1'b1;
    go(OAG_M_REG, 8'h03); ck(16'h0053, OAG_E_NONE);
    req_short = 1'b0;
    go(OAG_M_REG, 8'hE3); ck(16'h0053, OAG_E_NONE);
    // a working set outside the populated file is still range checked
    reg_ptr = 8'hA0;
    go(OAG_M_REG, 8'hE3); ck(16'h00A3, OAG_E_RANGE);
    reg_ptr = 8'h70;
    go(OAG_M_REG, 8'hE3); ck(16'h0073, OAG_E_NONE);
    go(OAG_M_PAIR, 8'hEE); chk("ea_pair", ea_pair, 16'h0001);
  endtask
  task t_pair;
    go(OAG_M_PAIR, 8'h7E); ck(16'h007E, OAG_E_NONE);
    go(OAG_M_PAIR, 8'hFE); ck(16'h00FE, OAG_E_NONE);
    go(OAG_M_PAIR, 8'h80); er(OAG_E_RANGE);
    go(OAG_M_PAIR, 8'h7F); er(OAG_E_ODD);
    req_short = 1'b1;
    go(OAG_M_PAIR, 8'h05); er(OAG_E_ODD);
    go(OAG_M_PAIR, 8'h0E); ck(16'h007E, OAG_E_NONE);
    req_short = 1'b0;
  endtask
  task t_ind;
    go(OAG_M_IND, 8'h10); ck(16'h004A, OAG_E_NONE);
    go(OAG_M_IND, 8'hF9); ck(16'h00A3, OAG_E_RANGE);
    go(OAG_M_IND_PAIR, 8'h20, OAG_K_LOAD, OAG_S_PROG); ck(16'h7A7B, OAG_E_NONE);
    chk("ea_space", ea_space, OAG_S_PROG);
    go(OAG_M_IND_PAIR, 8'h20, OAG_K_LOAD, OAG_S_DATA); chk("ea_space", ea_space, OAG_S_DATA);
    go(OAG_M_IND_PAIR, 8'h20, OAG_K_LOAD, OAG_S_REG); er(OAG_E_SPACE);
    go(OAG_M_IND, 8'h10, OAG_K_OTHER, OAG_S_DATA); er(OAG_E_SPACE);
  endtask
  task t_idx;
    reg_ptr = 8'h30;
    req_index = 4'h5;
    req_base = 8'h10;
    go(OAG_M_IDX, 8'h00, OAG_K_LOAD); ck(16'h007F, OAG_E_NONE);
    go(OAG_M_IDX, 8'h00); er(OAG_E_MODE);
  endtask
  task t_dir;
    req_direct = 16'hBEEF;
    go(OAG_M_DIR, 8'h00, OAG_K_COND_JUMP); ck(16'hBEEF, OAG_E_NONE);
    go(OAG_M_DIR, 8'h00, OAG_K_CALL); ck(16'hBEEF, OAG_E_NONE);
    go(OAG_M_DIR, 8'h00); er(OAG_E_MODE);
  endtask
  task t_rel;
    pc_next = 16'h1000;
    req_field = 8'h80;
    go(OAG_M_REL, 8'h00, OAG_K_REL_JUMP); ck(16'h0F80, OAG_E_NONE);
    req_field = 8'h7F;
    go(OAG_M_REL, 8'h00, OAG_K_DEC_BRANCH); ck(16'h107F, OAG_E_NONE);
    pc_next = 16'hFFF0;
    req_field = 8'h20;
    go(OAG_M_REL, 8'h00, OAG_K_REL_JUMP); ck(16'h0010, OAG_E_NONE);
    go(OAG_M_REL, 8'h00); er(OAG_E_MODE);
    go(OAG_M_REG, 8'h10, OAG_K_REL_JUMP); er(OAG_E_MODE);
  endtask
  task t_imm;
    req_field = 8'hA5;
    go(OAG_M_IMM, 8'h00); chk("ea_imm_data", ea_imm_data, 16'h00A5);
    chk("ea_imm", ea_imm, 16'h0001);
  endtask
  // request stays valid; a low ce must hold the old result
  task t_ce;
    req_field = 8'h3C;
    ce = 1'b0;
    repeat (3) @(negedge clk);
    chk("ea_imm_data", ea_imm_data, 16'h00A5);
    ce = 1'b1;
    @(negedge clk);
    chk("ea_imm_data", ea_imm_data, 16'h003C);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    t_reg; t_work; t_pair; t_ind; t_idx; t_dir; t_rel; t_imm; t_ce;
    conclude;
  end
  // 31 requests of at most 6 cycles each
  initial begin
    #20000;
    error_cnt++;
    conclude;
  end
endmodule // tb
`default_nettype wire
